// [logic/pusseq_defines.svh]
// Offsets, field positions, reset values and timing counts of the power-up sequencer.
`ifndef PUSSEQ_DEFINES_SVH
`define PUSSEQ_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PUSSEQ_OFF_CTRL 8'h00
`define PUSSEQ_OFF_STATUS 8'h04
`define PUSSEQ_OFF_FAULT 8'h08
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PUSSEQ_CTRL_RESTART 0
`define PUSSEQ_CTRL_SHDN_RECOVER 1
`define PUSSEQ_FLT_UV 3
`define PUSSEQ_FLT_OV 2
`define PUSSEQ_FLT_OCD 1
`define PUSSEQ_FLT_SCD 0
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PUSSEQ_CTRL_RST 32'h0000_0000
`define PUSSEQ_CLK_HZ 20000000
`define PUSSEQ_CHECK_MS 50
`define PUSSEQ_DONE_MS 100
`define PUSSEQ_UV_OFF_US 500
`endif

// [logic/pusseq_pkg.sv]
// Types shared by the power-up sequencer.
package pusseq_pkg;
  typedef enum logic [1:0] {
    PUSSEQ_IDLE = 2'b00,
    PUSSEQ_HOLD = 2'b01,
    PUSSEQ_RECOVER = 2'b10,
    PUSSEQ_RUN = 2'b11
  } pusseq_state_t;

  typedef struct packed {
    logic uv;
    logic ov;
    logic discharge_overcurrent_comparator;
    logic discharge_short_comparator;
  } pusseq_cmp_t;
endpackage

// [logic/pusseq_top.sv]
// Power-up safety sequencer with gate-drive shutdown and Wishbone status.
// Behaviour
// - Sequence starts when digital reset releases.
// - Not complete: gates low, hysteresis selects high.
// - At 50 ms strobe samples four comparators.
// - Any sampled fault sets internal fault bit.
// - Wait further 50 ms for corrupted samples.
// - At 100 ms drive power-up complete high.
// - No fault: gates and hysteresis go normal.
// - Fault present: enter matching protection state.
// - Other fault checks only after sequence completes.
// - Sequence runs after reset or regulator-off.
// - Rerun sequence on shutdown recovery after charger.
// - Reservoir undervoltage drives both gates low.
// - System undervoltage disables gates within 500 us.
// - Lockout flag high while supply below threshold.
// - Wake flag high while charger attached.
// - Status flags set on detected under/overvoltage.
// - Works regardless of cell connection order.
// - Serial configuration works with ground, supply only.
`timescale 1ns/1ps
`include "pusseq_defines.svh"
module pusseq_top
  import pusseq_pkg::*;
#(
  parameter int CLK_HZ = `PUSSEQ_CLK_HZ,
  parameter int CHECK_CYC = (`PUSSEQ_CHECK_MS * (CLK_HZ / 1000)),
  parameter int DONE_CYC = (`PUSSEQ_DONE_MS * (CLK_HZ / 1000))
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,

  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,

  // Sequence restarts.
  input wire logic regulator_off_i,
  input wire logic shutdown_recover_i,

  // Comparators sampled by the strobe.
  input wire logic uv_cmp_i,
  input wire logic ov_cmp_i,
  input wire logic discharge_overcurrent_comparator_i,
  input wire logic discharge_short_comparator_i,

  // Late faults.
  input wire logic charge_short_check_i,
  input wire logic overtemperature_check_i,
  input wire logic thermistor_check_i,

  // Outside recovery event.
  input wire logic fault_cleared_i,

  // Gate kill sources.
  input wire logic charge_drive_reservoir_uv_i,
  input wire logic discharge_drive_reservoir_uv_i,
  input wire logic system_uv_i,

  // Supply and charger levels.
  input wire logic supply_pin_below_por_i,
  input wire logic charger_attached_i,

  // Gate drives and hysteresis selects.
  output logic charge_gate_drive_o,
  output logic discharge_gate_drive_o,
  output logic undervoltage_hysteresis_select_o,
  output logic overvoltage_hysteresis_select_o,

  // Sequence progress.
  output logic power_up_complete_o,
  output logic safety_check_strobe_o,
  output logic fault_status_o,

  // Internal status flags.
  output logic supply_lockout_flag_o,
  output logic charger_wake_flag_o,
  output logic undervoltage_status_flag_o,
  output logic overvoltage_status_flag_o,
  output logic [3:0] protect_cause_o
);

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int UV_OFF_CYC_RAW = (`PUSSEQ_UV_OFF_US * (CLK_HZ / 1000000));
  localparam int UV_OFF_CYC = (UV_OFF_CYC_RAW < 1) ? 1 : UV_OFF_CYC_RAW;
  localparam int CW = $clog2(DONE_CYC + 1);
  localparam logic [CW-1:0] CHECK_PT = CW'(CHECK_CYC);
  localparam logic [CW-1:0] DONE_PT = CW'(DONE_CYC);

  // ----------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------
  pusseq_state_t state_q;
  logic [CW-1:0] seq_cnt_q;
  pusseq_cmp_t cmp_now;
  pusseq_cmp_t sample_q;
  logic sw_restart_q;
  logic start_seq;
  logic gate_kill;
  logic gates_ok;

  assign cmp_now = '{uv: uv_cmp_i,
                     ov: ov_cmp_i,
                     discharge_overcurrent_comparator: discharge_overcurrent_comparator_i,
                     discharge_short_comparator: discharge_short_comparator_i};

  // ----------------------------------------------------------------
  // Restart sources
  // ----------------------------------------------------------------
  // A restart from regulator-off, shutdown recovery or software reruns the checks.
  assign start_seq = regulator_off_i | shutdown_recover_i | sw_restart_q;

  // ----------------------------------------------------------------
  // Gate kill
  // ----------------------------------------------------------------
  // Gate kill is combinational into the gate flops so a reservoir collapse costs one cycle.
  assign gate_kill = charge_drive_reservoir_uv_i |
                     discharge_drive_reservoir_uv_i |
                     system_uv_i;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PUSSEQ_HOLD;
      seq_cnt_q <= '0;
    end else if (ce_i) begin
      if (start_seq) begin
        state_q <= PUSSEQ_HOLD;
        seq_cnt_q <= '0;
      end else begin
        case (state_q)
          PUSSEQ_HOLD: begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
            if (seq_cnt_q == CHECK_PT - 1'b1) begin
              state_q <= PUSSEQ_RECOVER;
            end
          end
          PUSSEQ_RECOVER: begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
            if (seq_cnt_q == DONE_PT - 1'b1) begin
              state_q <= PUSSEQ_RUN;
            end
          end
          PUSSEQ_RUN: begin
            state_q <= PUSSEQ_RUN;
          end
          default: begin
            state_q <= PUSSEQ_HOLD;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Safety sample
  // ----------------------------------------------------------------
  logic strobe_now;
  logic [3:0] cmp_vec;
  logic [3:0] sample_vec_q;

  // The strobe and the sample share the last hold edge.
  assign strobe_now = (state_q == PUSSEQ_HOLD) && (seq_cnt_q == CHECK_PT - 1'b1);
  assign cmp_vec = cmp_now;
  assign sample_q = sample_vec_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      safety_check_strobe_o <= 1'b0;
    end else if (ce_i) begin
      safety_check_strobe_o <= strobe_now && !start_seq;
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_sample
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sample_vec_q[b] <= 1'b0;
      end else if (ce_i) begin
        if (start_seq) begin
          sample_vec_q[b] <= 1'b0;
        end else if (strobe_now) begin
          // Sampled directly, with no fault filter delays.
          sample_vec_q[b] <= cmp_vec[b];
        end else if (state_q == PUSSEQ_RECOVER) begin
          // A corrupted sample clears once the comparator reads clean again.
          sample_vec_q[b] <= sample_vec_q[b] & cmp_vec[b];
        end else if (state_q == PUSSEQ_RUN && fault_cleared_i) begin
          sample_vec_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_status_o <= 1'b0;
    end else if (ce_i) begin
      fault_status_o <= |sample_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      protect_cause_o <= 4'h0;
    end else if (ce_i) begin
      if (state_q == PUSSEQ_RUN) begin
        protect_cause_o <= sample_q;
      end else begin
        protect_cause_o <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate drives and hysteresis selects
  // ----------------------------------------------------------------
  // Late faults are honoured only once the sequence is complete.
  assign gates_ok = (state_q == PUSSEQ_RUN) &&
                    (sample_q == '0) &&
                    !charge_short_check_i &&
                    !overtemperature_check_i &&
                    !thermistor_check_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_gate_drive_o <= 1'b0;
      discharge_gate_drive_o <= 1'b0;
      undervoltage_hysteresis_select_o <= 1'b1;
      overvoltage_hysteresis_select_o <= 1'b1;
    end else if (ce_i) begin
      if (state_q != PUSSEQ_RUN || start_seq) begin
        charge_gate_drive_o <= 1'b0;
        discharge_gate_drive_o <= 1'b0;
        undervoltage_hysteresis_select_o <= 1'b1;
        overvoltage_hysteresis_select_o <= 1'b1;
      end else begin
        charge_gate_drive_o <= gates_ok && !gate_kill && !sample_q.ov;
        discharge_gate_drive_o <= gates_ok && !gate_kill;
        undervoltage_hysteresis_select_o <= sample_q.uv;
        overvoltage_hysteresis_select_o <= sample_q.ov;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_up_complete_o <= 1'b0;
    end else if (ce_i) begin
      power_up_complete_o <= (state_q == PUSSEQ_RUN) && !start_seq;
    end
  end

  // ----------------------------------------------------------------
  // Internal status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_lockout_flag_o <= 1'b1;
      charger_wake_flag_o <= 1'b0;
    end else if (ce_i) begin
      supply_lockout_flag_o <= supply_pin_below_por_i;
      charger_wake_flag_o <= charger_attached_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      undervoltage_status_flag_o <= 1'b0;
      overvoltage_status_flag_o <= 1'b0;
    end else if (ce_i) begin
      undervoltage_status_flag_o <= uv_cmp_i | sample_q.uv;
      overvoltage_status_flag_o <= ov_cmp_i | sample_q.ov;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Only the clock and supply are needed for this port, so it ignores sequence state.
  logic wb_req;
  logic adr_ok;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign adr_ok = (wb_adr_i == `PUSSEQ_OFF_CTRL) ||
                  (wb_adr_i == `PUSSEQ_OFF_STATUS) ||
                  (wb_adr_i == `PUSSEQ_OFF_FAULT);

  // A restart write is a one-cycle pulse, but a held bus re-requests every second cycle and retriggers the sequence each time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_restart_q <= 1'b0;
    end else if (ce_i) begin
      sw_restart_q <= 1'b0;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PUSSEQ_OFF_CTRL) begin
        sw_restart_q <= wb_dat_i[`PUSSEQ_CTRL_RESTART];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus response and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req && adr_ok;
      wb_err_o <= wb_req && !adr_ok;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `PUSSEQ_OFF_STATUS: begin
            wb_dat_o <= {21'h00_0000,
                         charger_wake_flag_o,
                         supply_lockout_flag_o,
                         overvoltage_status_flag_o,
                         undervoltage_status_flag_o,
                         fault_status_o,
                         power_up_complete_o,
                         discharge_gate_drive_o,
                         charge_gate_drive_o,
                         state_q,
                         1'b0};
          end
          `PUSSEQ_OFF_FAULT: begin
            wb_dat_o <= {28'h000_0000, sample_q};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Cell order independence: no input here depends on cell attach order.
endmodule

// [tb/pusseq_asserts.sv]
// Port-level assertions for the power-up sequencer.
`timescale 1ns/1ps
module pusseq_asserts #(
  parameter int CHECK_CYC = 10,
  parameter int DONE_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic uv_cmp_i,
  input wire logic charge_drive_reservoir_uv_i,
  input wire logic discharge_drive_reservoir_uv_i,
  input wire logic system_uv_i,
  input wire logic supply_pin_below_por_i,
  input wire logic charger_attached_i,
  input wire logic charge_gate_drive_o,
  input wire logic discharge_gate_drive_o,
  input wire logic undervoltage_hysteresis_select_o,
  input wire logic overvoltage_hysteresis_select_o,
  input wire logic power_up_complete_o,
  input wire logic safety_check_strobe_o,
  input wire logic fault_status_o,
  input wire logic supply_lockout_flag_o,
  input wire logic charger_wake_flag_o,
  input wire logic undervoltage_status_flag_o
);
  // The strobe-to-complete spacing is fixed by the two sequence points.
  localparam int GAP = DONE_CYC - CHECK_CYC + 1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_gates_held_low: assert property (
    !power_up_complete_o && !$past(power_up_complete_o) |->
    !charge_gate_drive_o && !discharge_gate_drive_o) else $error("gate on before completion");
  a_hyst_held_high: assert property (
    !power_up_complete_o && !$past(power_up_complete_o) |->
    undervoltage_hysteresis_select_o && overvoltage_hysteresis_select_o) else $error("hyst low");
  a_strobe_single: assert property (
    safety_check_strobe_o |=> !safety_check_strobe_o [*8]) else $error("strobe repeated");
  a_done_after_strobe: assert property (
    $rose(power_up_complete_o) |-> $past(safety_check_strobe_o, GAP)) else $error("done spacing");
  a_fault_blocks_gates: assert property (
    $rose(power_up_complete_o) && fault_status_o |->
    !charge_gate_drive_o && !discharge_gate_drive_o) else $error("gates on with fault");
  a_reservoir_kill: assert property (
    charge_drive_reservoir_uv_i || discharge_drive_reservoir_uv_i || system_uv_i |=>
    !charge_gate_drive_o && !discharge_gate_drive_o) else $error("gates not killed");
  a_lockout_follows: assert property (
    supply_pin_below_por_i |=> supply_lockout_flag_o) else $error("lockout flag low");
  a_wake_follows: assert property (
    charger_attached_i |=> charger_wake_flag_o) else $error("wake flag low");
  a_undervoltage_status_flag_set: assert property (
    uv_cmp_i |=> undervoltage_status_flag_o) else $error("undervoltage_status_flag low");
  c_done: cover property ($rose(power_up_complete_o));
  c_fault: cover property ($rose(power_up_complete_o) && fault_status_o);
  c_kill: cover property (system_uv_i && power_up_complete_o);
endmodule
bind pusseq_top pusseq_asserts #(.CHECK_CYC(CHECK_CYC), .DONE_CYC(DONE_CYC))
  pusseq_asserts_inst (.*);

// [tb/pusseq_pack_model.sv]
// Behavioural cell stack and load facing the sequencer.
`timescale 1ns/1ps
module pusseq_pack_model
  import pusseq_pkg::*;
(
  input wire logic clk_i,
  input wire pusseq_cmp_t cell_fault_i,
  input wire logic load_removed_i,
  output pusseq_cmp_t cmp_o,
  output logic fault_cleared_o
);
  // Comparators lag the stack by a cycle, as a real filter would.
  always_ff @(posedge clk_i) begin
    cmp_o <= cell_fault_i;
  end
  // Lifting the load is the outside event that frees a latched fault.
  always_ff @(posedge clk_i) begin
    fault_cleared_o <= load_removed_i;
  end
endmodule

// [tb/pusseq_tb_top.sv]
// Self-checking bench for the power-up sequencer.
`timescale 1ns/1ps
`include "pusseq_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module pusseq_tb_top
  import pusseq_pkg::*;
;
  localparam int CHECK_CYC = 10;
  localparam int DONE_CYC = 20;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er, load_rm;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, protect_cause_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic regulator_off_i, shutdown_recover_i, uv_cmp_i, ov_cmp_i, fault_cleared_i;
  logic discharge_overcurrent_comparator_i, discharge_short_comparator_i, system_uv_i;
  logic charge_short_check_i, overtemperature_check_i, thermistor_check_i;
  logic charge_drive_reservoir_uv_i, discharge_drive_reservoir_uv_i, fault_status_o;
  logic supply_pin_below_por_i, charger_attached_i, charge_gate_drive_o, discharge_gate_drive_o;
  logic undervoltage_hysteresis_select_o, overvoltage_hysteresis_select_o;
  logic power_up_complete_o, safety_check_strobe_o, supply_lockout_flag_o;
  logic charger_wake_flag_o, undervoltage_status_flag_o, overvoltage_status_flag_o;
  pusseq_cmp_t flt, cmp;
  int num_errors = 0;
  int samples_checked = 0;
  pusseq_top #(.CHECK_CYC(CHECK_CYC), .DONE_CYC(DONE_CYC)) pusseq_top_inst (.*);
  pusseq_pack_model pusseq_pack_model_inst (.clk_i(clk_i), .cell_fault_i(flt),
    .load_removed_i(load_rm), .cmp_o(cmp), .fault_cleared_o(fault_cleared_i));
  assign uv_cmp_i = cmp.uv;
  assign ov_cmp_i = cmp.ov;
  assign discharge_overcurrent_comparator_i = cmp.discharge_overcurrent_comparator;
  assign discharge_short_comparator_i = cmp.discharge_short_comparator;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Restart kinds: 0 reset, 1 control write, 2 regulator off, 3 shutdown recovery.
  task automatic run_seq(input int how, input logic [3:0] m, input logic gl);
    int n;
    logic [3:0] e;
    e = gl ? 4'h0 : m;
    flt <= m;
    @(posedge clk_i);
    rst_i <= (how == 0);
    regulator_off_i <= (how == 2);
    shutdown_recover_i <= (how == 3);
    repeat (how == 0 ? 20 : 1) @(posedge clk_i);
    {rst_i, regulator_off_i, shutdown_recover_i} <= 3'b000;
    if (how == 1) wb(`PUSSEQ_OFF_CTRL, 1'b1, 32'h0000_0001);
    n = 0;
    while (safety_check_strobe_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (gl) begin
      flt <= 4'h0;
      {charge_short_check_i, overtemperature_check_i, thermistor_check_i} <= 3'b000;
    end
    n = 0;
    while (power_up_complete_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("gap", DONE_CYC - CHECK_CYC + 1, n)
    repeat (2) @(posedge clk_i);
    `CHK("gates", {2{e == 4'h0}}, {charge_gate_drive_o, discharge_gate_drive_o})
    `CHK("cause", e, protect_cause_o)
    `CHK("fault", |e, fault_status_o)
    if (e == 4'h0) `CHK("hyst", 2'b00, {undervoltage_hysteresis_select_o,
      overvoltage_hysteresis_select_o})
    wb(`PUSSEQ_OFF_STATUS, 1'b0, 32'h0000_0000);
    `CHK("status", {|e, 1'b1}, rd[6:5])
    wb(`PUSSEQ_OFF_FAULT, 1'b0, 32'h0000_0000);
    `CHK("fault_reg", {e[0], e[3]}, {rd[`PUSSEQ_FLT_SCD], rd[`PUSSEQ_FLT_UV]})
    if (e != 4'h0) begin
      flt <= 4'h0;
      load_rm <= 1'b1;
      @(posedge clk_i);
      load_rm <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK("recover", 2'b11, {charge_gate_drive_o, discharge_gate_drive_o})
    end
    $display("test restart %0d mask %0h done", how, m);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    print_verdict();
  end
  initial begin
    int i;
    {rst_i, ce_i, wb_sel_i} = 6'b11_1111;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {regulator_off_i, shutdown_recover_i, load_rm, charge_short_check_i} = '0;
    {overtemperature_check_i, thermistor_check_i, system_uv_i} = '0;
    {charge_drive_reservoir_uv_i, discharge_drive_reservoir_uv_i} = '0;
    {supply_pin_below_por_i, charger_attached_i} = '0;
    flt = '0;
    seed = 32'h0000_003A;
    run_seq(0, 4'h0, 1'b0);
    for (i = 0; i < 4; i++) run_seq(i % 3 + 1, 4'h1 << i, 1'b0);
    run_seq(2, 4'h8, 1'b1);
    {charge_short_check_i, overtemperature_check_i, thermistor_check_i} <= 3'b111;
    run_seq(3, 4'h0, 1'b1);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      {supply_pin_below_por_i, charger_attached_i} <= seed[1:0];
      {system_uv_i, charge_drive_reservoir_uv_i, discharge_drive_reservoir_uv_i} <=
        3'b001 << (seed[3:2] % 3);
      repeat (2) @(posedge clk_i);
      `CHK("lockout", seed[1], supply_lockout_flag_o)
      `CHK("wake", seed[0], charger_wake_flag_o)
      `CHK("kill", 2'b00, {charge_gate_drive_o, discharge_gate_drive_o})
    end
    {system_uv_i, charge_drive_reservoir_uv_i, discharge_drive_reservoir_uv_i} <= 3'b000;
    {supply_pin_below_por_i, charger_attached_i} <= 2'b00;
    $display("test flags and kills done");
    run_seq(1, 4'h0, 1'b0);
    overtemperature_check_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("late", 2'b00, {charge_gate_drive_o, discharge_gate_drive_o})
    wb(8'h0C, 1'b0, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    $display("test late fault and bus done");
    print_verdict();
  end
endmodule
